/* File: bench/lpm_chk_assertions.sv */
// Port assertions for the mode controller
`timescale 1ns/1ps
module lpm_chk
	import lpm_pkg::*;
(
	input wire logic clk, srst, resetPinN, sleepInstruction, stopInstruction, watchSelectBit,
	input wire logic globalIrqEnable, irqPending, cpuClockEn, peripheralClockEn, timeBaseClockEn,
	input wire logic mainOscEn, subOscSelect, instrNop, irqServiceEn, pinHold, pinFloat,
	input lpm_mode_t modeOut
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire logic act = modeOut == LPM_ACTIVE;
	// Cancelled requests must not move the mode
	wire logic go = act && (globalIrqEnable || !irqPending);
	property p_actGate; act |-> cpuClockEn && peripheralClockEn && mainOscEn && !subOscSelect; endproperty
	a_actGate: assert property (p_actGate) else $error("active gates");
	property p_sbyGate; modeOut == LPM_STANDBY |-> !cpuClockEn && peripheralClockEn && mainOscEn && pinHold; endproperty
	a_sbyGate: assert property (p_sbyGate) else $error("standby gates");
	property p_stopGate; modeOut == LPM_STOP |-> !cpuClockEn && !peripheralClockEn && !mainOscEn && pinFloat; endproperty
	a_stopGate: assert property (p_stopGate) else $error("stop gates");
	property p_wchGate; modeOut == LPM_WATCH |-> !cpuClockEn && !peripheralClockEn && timeBaseClockEn; endproperty
	a_wchGate: assert property (p_wchGate) else $error("watch gates");
	property p_sleep; go && sleepInstruction |=> modeOut == LPM_STANDBY; endproperty
	a_sleep: assert property (p_sleep) else $error("no standby");
	property p_stop; go && stopInstruction |=> modeOut == ($past(watchSelectBit) ? LPM_WATCH : LPM_STOP); endproperty
	a_stop: assert property (p_stop) else $error("stop entry");
	property p_nop; act && (sleepInstruction || stopInstruction) && !go |=> act && instrNop; endproperty
	a_nop: assert property (p_nop) else $error("no cancel");
	property p_stopHold; (modeOut == LPM_STOP && resetPinN) [*3] |=> modeOut == LPM_STOP; endproperty
	a_stopHold: assert property (p_stopHold) else $error("stop left");
	property p_subGate; modeOut == LPM_SUBACTIVE |-> cpuClockEn && peripheralClockEn && subOscSelect && !mainOscEn; endproperty
	a_subGate: assert property (p_subGate) else $error("subactive gates");
	property p_svc; globalIrqEnable && irqPending && cpuClockEn |=> irqServiceEn; endproperty
	a_svc: assert property (p_svc) else $error("no service");
endmodule : lpm_chk
bind lpm_mode_ctrl lpm_chk lpm_chk_inst (.*);

/* File: bench/lpm_cpu_model.sv */
// CPU side model issuing the low power instructions
`timescale 1ns/1ps
module lpm_cpu_model
	import lpm_pkg::*;
(
	input wire logic [1:0] op,
	input lpm_mode_t mode,
	output logic sleepInstruction,
	output logic stopInstruction
);
	// A halted CPU executes nothing, so requests outside running modes are dropped
	wire logic runs = mode == LPM_ACTIVE || mode == LPM_SUBACTIVE;
	assign sleepInstruction = runs && op == 2'h1;
	assign stopInstruction = runs && op == 2'h2;
endmodule : lpm_cpu_model

/* File: bench/lpm_mode_ctrl_tb_top.sv */
// Self-checking bench for the mode controller
`timescale 1ns/1ps
module lpm_mode_ctrl_tb_top;
	import lpm_pkg::*;
	logic clk = 0, srst = 1, rstN = 1, wsel = 0, lso = 0, dto = 0, gie = 1, irq = 0, ext0 = 0, tmra = 0;
	logic sleepI, stopI, nop;
	logic [1:0] op = 2'h0;
	lpm_mode_t mode, prevMode;
	logic [3:0] q[$];
	logic [31:0] rnd = 32'h0000_d3a0;
	int error_cnt = 0, comparisons = 0, cyc = 0;
	lpm_mode_ctrl #(.SETTLE_CYC(4)) lpm_mode_ctrl_inst (.clk(clk), .srst(srst), .resetPinN(rstN),
		.sleepInstruction(sleepI), .stopInstruction(stopI), .watchSelectBit(wsel), .lowSpeedOnFlag(lso),
		.directTransferFlag(dto), .globalIrqEnable(gie), .irqPending(irq), .externalIrqZero(ext0),
		.timerAIrq(tmra), .cpuClockEn(), .peripheralClockEn(), .timeBaseClockEn(), .mainOscEn(),
		.subOscSelect(), .instrNop(nop), .irqServiceEn(), .cpuRegsReset(), .pinHold(), .pinFloat(),
		.modeOut(mode));
	lpm_cpu_model lpm_cpu_model_inst (.op(op), .mode(mode), .sleepInstruction(sleepI), .stopInstruction(stopI));
	initial forever #5 clk = ~clk;
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle
	task automatic exp(input lpm_mode_t m, input logic n);
		q.push_back({n, m});
	endtask : exp
	task automatic run(input logic [1:0] o);
		@(negedge clk) op = o;
		@(negedge clk) op = 2'h0;
		rnd = lfsr(rnd);
		idle(rnd[1:0] + 2);
	endtask : run
	task automatic kick(input logic [1:0] w);
		{ext0, tmra} = w;
		idle(1);
		{ext0, tmra} = 2'h0;
		idle(8);
	endtask : kick
	task automatic cmp(input logic [3:0] e);
		comparisons++;
		if ({nop, mode} !== e)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, {nop, mode}, e);
		end
	endtask : cmp
	task automatic give_verdict();
		if (error_cnt == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////////
	// Each mode change or cancel pulse takes the oldest expectation
	always @(posedge clk)
	begin
		#1;
		if (!srst && (mode !== prevMode || nop === 1'b1))
			cmp(q.size() ? q.pop_front() : 4'hf);
		prevMode = mode;
		cyc++;
		if (cyc == 2000)
		begin
			error_cnt++;
			give_verdict();
		end
	end
	initial
	begin
		idle(6);
		srst = 0;
		idle(2);
		exp(LPM_STANDBY, 0);
		run(2'h1);
		exp(LPM_ACTIVE, 0);
		irq = 1;
		idle(3);
		gie = 0;
		exp(LPM_ACTIVE, 1);
		run(2'h1);
		exp(LPM_ACTIVE, 1);
		run(2'h2);
		gie = 1;
		irq = 0;
		exp(LPM_STOP, 0);
		run(2'h2);
		repeat (20)
		begin
			rnd = lfsr(rnd);
			{irq, ext0, tmra} = rnd[2:0];
			@(negedge clk);
		end
		{irq, ext0, tmra} = 3'h0;
		exp(LPM_ACTIVE, 0);
		rstN = 0;
		idle(12);
		rstN = 1;
		idle(4);
		wsel = 1;
		exp(LPM_WATCH, 0);
		run(2'h2);
		exp(LPM_SETTLE, 0);
		exp(LPM_ACTIVE, 0);
		kick(2'h2);
		lso = 1;
		exp(LPM_WATCH, 0);
		run(2'h2);
		exp(LPM_SUBACTIVE, 0);
		kick(2'h1);
		exp(LPM_WATCH, 0);
		run(2'h1);
		exp(LPM_SUBACTIVE, 0);
		kick(2'h1);
		lso = 0;
		dto = 1;
		exp(LPM_SETTLE, 0);
		exp(LPM_ACTIVE, 0);
		run(2'h2);
		idle(8);
		if (q.size() != 0)
		begin
			error_cnt++;
			$display("[FAIL] %0t results missing", $time);
		end
		give_verdict();
	end
endmodule : lpm_mode_ctrl_tb_top

/* File: rtl/lpm_gate_decode.sv */
// Clock gate and pin state decoder for each operating mode
`timescale 1ns/1ps
module lpm_gate_decode
	import lpm_pkg::*;
(
	// Mode in, gates out
	lpm_gate_if.dec gi
);
	wire isAct = (gi.mode == LPM_ACTIVE);
	wire isSub = (gi.mode == LPM_SUBACTIVE);
	wire isSby = (gi.mode == LPM_STANDBY);
	wire isWatch = (gi.mode == LPM_WATCH);
	wire isSettle = (gi.mode == LPM_SETTLE);
	assign gi.cpuRun = isAct | isSub;
	assign gi.perRun = isAct | isSub | isSby;
	assign gi.tbRun = isAct | isSub | isSby | isWatch | isSettle;
	assign gi.mainOscOn = isAct | isSby | isSettle;
	assign gi.subOscSel = isSub;
	assign gi.pinHold = isSby | isWatch | isSettle;
	assign gi.pinFloat = (gi.mode == LPM_STOP);
endmodule : lpm_gate_decode

/* File: rtl/lpm_mode_ctrl.sv */
// Operating mode controller: active, standby, stop, watch and subactive
`timescale 1ns/1ps
module lpm_mode_ctrl
	import lpm_pkg::*;
#(
	parameter bit SUBACTIVE_FITTED = 1'b1,
	parameter int SETTLE_CYC = LPM_SETTLE_CYC
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Asynchronous reset pin, active low
	input wire logic resetPinN,
	// Instruction decoder
	input wire logic sleepInstruction,
	input wire logic stopInstruction,
	input wire logic watchSelectBit,
	input wire logic lowSpeedOnFlag,
	input wire logic directTransferFlag,
	// Interrupt logic
	input wire logic globalIrqEnable,
	input wire logic irqPending,
	input wire logic externalIrqZero,
	input wire logic timerAIrq,
	// Clock gates and oscillators
	output logic cpuClockEn,
	output logic peripheralClockEn,
	output logic timeBaseClockEn,
	output logic mainOscEn,
	output logic subOscSelect,
	// CPU and pin control
	output logic instrNop,
	output logic irqServiceEn,
	output logic cpuRegsReset,
	output logic pinHold,
	output logic pinFloat,
	output lpm_mode_t modeOut
);
	////////////////////////////////////////////////////////////////////////////////
	// Reset pin synchroniser; the pin is asynchronous to clk
	logic rstMeta_q;
	logic rstSync_q;
	always_ff @(posedge clk)
	begin
		rstMeta_q <= ~resetPinN;
		rstSync_q <= rstMeta_q;
	end
	// Pin reset wins over any mode, stop included
	wire anyReset = srst | rstSync_q;

	////////////////////////////////////////////////////////////////////////////////
	// Mode state
	lpm_mode_t mode_q;
	lpm_mode_t mode_d;
	logic [LPM_CNT_W-1:0] settle_q;
	logic [LPM_CNT_W-1:0] settle_d;
	logic stopped_q;
	lpm_gate_if gi();
	assign gi.mode = mode_q;

	lpm_gate_decode u_dec (
		.gi(gi)
	);

	// A pending unmasked request with enable off cancels the instruction
	wire lowPowerReq = (sleepInstruction | stopInstruction);
	wire cancelReq = lowPowerReq & ~globalIrqEnable & irqPending;
	wire goReq = lowPowerReq & ~cancelReq;
	wire watchWake = externalIrqZero | timerAIrq;
	// Direct transfer only honoured with low speed flag clear
	wire directGo = directTransferFlag & ~lowSpeedOnFlag;

	always_comb
	begin
		mode_d = mode_q;
		settle_d = settle_q;
		case (mode_q)
			LPM_ACTIVE:
			begin
				if (goReq & stopInstruction)
					mode_d = watchSelectBit ? LPM_WATCH : LPM_STOP;
				else if (goReq & sleepInstruction)
					mode_d = LPM_STANDBY;
			end
			LPM_STANDBY:
			begin
				if (irqPending)
					mode_d = LPM_ACTIVE;
			end
			LPM_STOP:
			begin
				// Interrupts ignored; only reset leaves
				mode_d = LPM_STOP;
			end
			LPM_WATCH:
			begin
				if (watchWake)
				begin
					if (SUBACTIVE_FITTED & lowSpeedOnFlag)
						mode_d = LPM_SUBACTIVE;
					else
					begin
						// Main oscillator restarts; wait before CPU runs
						mode_d = LPM_SETTLE;
						settle_d = LPM_CNT_W'(SETTLE_CYC);
					end
				end
			end
			LPM_SUBACTIVE:
			begin
				if (goReq)
				begin
					if (directGo)
					begin
						mode_d = LPM_SETTLE;
						settle_d = LPM_CNT_W'(SETTLE_CYC);
					end
					else
						mode_d = LPM_WATCH;
				end
			end
			LPM_SETTLE:
			begin
				if (settle_q <= LPM_CNT_W'(1))
					mode_d = LPM_ACTIVE;
				else
					settle_d = settle_q - LPM_CNT_W'(1);
			end
			default:
			begin
				mode_d = LPM_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (anyReset)
		begin
			mode_q <= LPM_ACTIVE;
			settle_q <= '0;
		end
		else
		begin
			mode_q <= mode_d;
			settle_q <= settle_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stop exit marker: CPU working registers invalid, RAM untouched
	always_ff @(posedge clk)
	begin
		if (srst)
			stopped_q <= 1'b0;
		else if (mode_q == LPM_STOP)
			stopped_q <= 1'b1;
		else if (~rstSync_q)
			stopped_q <= 1'b0;
	end

	// Registered outputs
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			instrNop <= 1'b0;
			irqServiceEn <= 1'b0;
		end
		else
		begin
			instrNop <= cancelReq & (mode_q == LPM_ACTIVE || mode_q == LPM_SUBACTIVE);
			irqServiceEn <= globalIrqEnable & irqPending & gi.cpuRun;
		end
	end

	assign cpuClockEn = gi.cpuRun;
	assign peripheralClockEn = gi.perRun;
	assign timeBaseClockEn = gi.tbRun;
	assign mainOscEn = gi.mainOscOn;
	assign subOscSelect = gi.subOscSel;
	assign pinHold = gi.pinHold;
	assign pinFloat = gi.pinFloat;
	// Pin reset scrubs CPU state only after stop; srst always does
	assign cpuRegsReset = anyReset & (stopped_q | srst);
	assign modeOut = mode_q;
endmodule : lpm_mode_ctrl

/* File: shared/lpm_gate_if.sv */
// Interface carrying the mode from the controller to the clock gate decoder
`timescale 1ns/1ps
interface lpm_gate_if;
	import lpm_pkg::*;
	lpm_mode_t mode;
	logic cpuRun;
	logic perRun;
	logic tbRun;
	logic mainOscOn;
	logic subOscSel;
	logic pinHold;
	logic pinFloat;
	modport ctrl (output mode, input cpuRun, perRun, tbRun, mainOscOn, subOscSel, pinHold, pinFloat);
	modport dec (input mode, output cpuRun, perRun, tbRun, mainOscOn, subOscSel, pinHold, pinFloat);
endinterface : lpm_gate_if

/* File: shared/lpm_pkg.sv */
// Package for the low power mode controller: modes, timing and rule summary
// Function
// - Five modes classified by CPU clock gate and peripheral clock gate.
// - Active mode clocks CPU and peripherals from the main oscillator.
// - Sleep instruction in active mode enters standby.
// - Standby gates only CPU clocks; oscillators, timers, serial run; state held.
// - Reset ends standby with reset; interrupt returns to active, next instruction.
// - Waking interrupt serviced only if global enable is 1, else left pending.
// - Stop instruction in active with watch select 0 enters stop; oscillator halts.
// - Stop instruction with watch select 1 enters watch mode instead.
// - Stop mode left only by reset; interrupts ignored while stopped.
// - RAM kept after stop; CPU working registers need not be valid.
// - Stop floats outputs; standby and watch hold output levels.
// - Watch runs only the time-base clock; timer A and display run.
// - External irq zero or timer A ends watch; subactive if fitted; reset too.
// - Subactive optional; runs from sub oscillator; exits by reset, stop or sleep.
// - Asynchronous reset returns to reset state from any mode.
// - Stop or sleep with enable off and a pending unmasked flag is a no-op.
// - Stop or sleep in subactive goes to watch or active per the two flags.
package lpm_pkg;
	typedef enum logic [2:0] {LPM_ACTIVE, LPM_STANDBY, LPM_STOP, LPM_WATCH, LPM_SUBACTIVE, LPM_SETTLE} lpm_mode_t;
	localparam int LPM_SETTLE_NS = 10000;
	localparam int LPM_CLK_NS = 10;
	localparam int LPM_SETTLE_CYC = (LPM_SETTLE_NS + LPM_CLK_NS - 1) / LPM_CLK_NS;
	localparam int LPM_CNT_W = 16;
	localparam logic LPM_RESET_WATCH = 1'b0;
endpackage : lpm_pkg
